/* smm_dev_model.sv */
// Behavioural monitor device answering on the management bus
`timescale 1ns/1ps
`default_nettype none
module smm_dev_model #(
	parameter logic [6:0] ADDR = 7'h5c,
	parameter logic [7:0] LEN_REG = 8'h00
) (
	// Open-drain bus: scl_low and sda_low high = pull low, alert_n low = pull low
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	output logic alert_n,
	// Behaviour selects
	input wire logic alert_req,
	input wire logic slow,
	input wire logic hang,
	input wire logic bad_pec
);
	import smm_pkg::*;
	logic [7:0] regs [256];
	logic [7:0] ptr, code, b, crc;
	logic rs, lost;

	assign alert_n = !alert_req;

	// Running CRC-8 kept independently of the master
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		repeat (8) x = x[7] ? (x << 1) ^ 8'h07 : x << 1;
		return x;
	endfunction

	// Slow answers stretch the clock; a hang holds it until the bench lets go
	task automatic hold_low();
		if (slow || hang) begin
			scl_low = 1'b1;
			#9000;
			if (hang) begin
				wait (!hang);
				sda_low = 1'b0;
			end
			scl_low = 1'b0;
		end
	endtask

	task automatic rx(output logic [7:0] d);
		@(negedge scl);
		#100 sda_low = 1'b0;
		repeat (8) begin
			@(posedge scl);
			d = {d[6:0], sda};
		end
		crc = crc8(crc, d);
	endtask

	task automatic ack(input logic a);
		@(negedge scl);
		#100 sda_low = a;
		hold_low();
	endtask

	// Send MSB first, backing off when a one is overridden
	task automatic tx(input logic [7:0] d);
		lost = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			@(negedge scl);
			#100 sda_low = !d[i] && !lost;
			@(posedge scl);
			if (d[i] && !sda) lost = 1'b1;
		end
		@(negedge scl);
		#100 sda_low = 1'b0;
		@(posedge scl);
		crc = crc8(crc, d);
	endtask

	// One addressed frame up to the next start or stop
	task automatic frame();
		logic [7:0] a, n;
		rx(a);
		if (a == {ALERT_RESP_ADDR, 1'b1} && !alert_n) begin
			ack(1'b1);
			tx({ADDR, 1'b1});
			return;
		end
		if (a[7:1] != ADDR) return;
		ack(1'b1);
		if (a[0]) begin
			if (code == BLOCK_RD_CODE) begin
				n = regs[LEN_REG] > 8'h20 ? 8'h20 : regs[LEN_REG];
				tx(n);
				for (int i = 0; i < n; i++) tx(regs[ptr + 8'(i)]);
				tx(crc ^ {7'h00, bad_pec});
			end else tx(regs[ptr]);
			return;
		end
		rx(code);
		ack(1'b1);
		if (code == BLOCK_WR_CODE) begin
			for (int i = 0; i < regs[LEN_REG]; i++) begin
				rx(b);
				ack(1'b1);
				regs[ptr + 8'(i)] = b;
			end
			n = crc;
			rx(b);
			ack(b == n && !bad_pec);
		end else if (code != BLOCK_RD_CODE) begin
			ptr = code;
			rx(b);
			ack(1'b1);
			regs[ptr] = b;
		end
		// Last acknowledge stands until the clock falls; the frame ends only at stop or repeated start
		@(negedge scl);
		#100 sda_low = 1'b0;
		wait (rs);
	endtask

	// Stop ends the frame, a repeated start opens the next one
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		ptr = 8'h00;
		foreach (regs[i]) regs[i] = 8'(i) ^ 8'h5a;
		forever begin
			@(negedge sda iff scl);
			crc = 8'h00;
			code = 8'h00;
			do begin
				rs = 1'b0;
				fork
					frame();
					@(posedge sda iff scl);
					begin
						@(negedge sda iff scl);
						rs = 1'b1;
					end
				join_any
				disable fork;
				sda_low = 1'b0;
				scl_low = 1'b0;
			end while (rs);
		end
	end
endmodule
`default_nettype wire

/* smm_fifo.sv */
// Byte FIFO with a registered read port for received block data
`timescale 1ns/1ps
`default_nettype none
module smm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and control
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
	logic [AW:0] count, next_count;
	logic next_out_valid;
	logic [WIDTH-1:0] next_out_data;
	logic push, pop;

	// Full only when every slot holds a byte, so the source really stalls
	assign in_ready = (count != (AW+1)'(DEPTH));

	// Pointer, count and output stage
	always_comb begin
		push = in_valid && in_ready;
		pop = (count != '0) && (!out_valid || out_ready);
		next_wptr = push ? wptr + 1'b1 : wptr;
		next_rptr = pop ? rptr + 1'b1 : rptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
		next_out_valid = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
		next_out_data = pop ? mem[rptr] : out_data;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			wptr <= '0;
			rptr <= '0;
			count <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (ce) begin
			if (push) begin
				mem[wptr] <= in_data;
			end
			wptr <= next_wptr;
			rptr <= next_rptr;
			count <= next_count;
			out_valid <= next_out_valid;
			out_data <= next_out_data;
		end
	end
endmodule
`default_nettype wire

/* smm_host.sv */
// Bus master that drives the monitor's serial management interface
`timescale 1ns/1ps
`default_nettype none
module smm_host #(
	parameter int TIMEOUT = smm_pkg::TIMEOUT_CYC
) (
	// Clock and control
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// Command and response
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire smm_pkg::smm_cmd_t cmd,
	output logic resp_valid,
	output smm_pkg::smm_resp_t resp,
	// Block write data
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	output logic wr_ready,
	// Block read data
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [7:0] rd_data,
	// Bus pins, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic alert_n_in,
	output logic alert_seen
);
	import smm_pkg::*;

	typedef enum {ST_IDLE, ST_START, ST_BYTE, ST_STOP, ST_FETCH, ST_PUSH} smm_state_t;
	typedef enum {SP_ADDR, SP_CMD, SP_DATA, SP_WBLK, SP_WPEC, SP_RADDR, SP_RBYTE, SP_RCOUNT, SP_RDATA,
		SP_RPEC} smm_step_t;

	smm_state_t st, next_st, go_state;
	smm_step_t step, next_step;
	smm_cmd_t cur, next_cur;
	smm_resp_t next_resp;
	logic [2:0] sync1, sync2;
	logic scl_s, sda_s;
	logic [1:0] q, next_q;
	logic [7:0] tick, next_tick;
	logic [3:0] bitn, next_bitn;
	logic [7:0] txb, next_txb, rxb, next_rxb, byte_val, next_byte_val, crc, next_crc, crc_new, bval, go_val;
	logic rd_dir, next_rd_dir, nack_out, next_nack_out;
	logic [5:0] cnt, next_cnt, rcount;
	logic [WDOG_W-1:0] wdog, next_wdog;
	logic next_scl_oe, next_sda_oe, next_cmd_ready, next_resp_valid, next_wr_ready;
	logic push_valid, next_push_valid, fifo_in_ready;
	logic qend, stretched, go_byte, go_rd, go_nack, go_seg;

	// Pins come from another domain: two flops before any logic looks at them
	always_ff @(posedge clock) begin
		if (srst) begin
			sync1 <= 3'h7;
			sync2 <= 3'h7;
		end else if (ce) begin
			sync1 <= {alert_n_in, sda_in, scl_in};
			sync2 <= sync1;
		end
	end
	assign scl_s = sync2[0];
	assign sda_s = sync2[1];

	// Received block bytes wait here; a full FIFO stalls the bus between bytes
	smm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.srst(srst),
		.ce(ce),
		.in_valid(push_valid),
		.in_ready(fifo_in_ready),
		.in_data(rxb),
		.out_valid(rd_valid),
		.out_ready(rd_ready),
		.out_data(rd_data)
	);

	// Sequencer: quarter-bit timing, byte shifting and protocol steps
	always_comb begin
		next_st = st;
		next_step = step;
		next_cur = cur;
		next_resp = resp;
		next_q = q;
		next_tick = (tick != 8'h00) ? tick - 8'h01 : tick;
		next_bitn = bitn;
		next_txb = txb;
		next_rxb = rxb;
		next_byte_val = byte_val;
		next_crc = crc;
		next_rd_dir = rd_dir;
		next_nack_out = nack_out;
		next_cnt = cnt;
		next_wdog = wdog;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		next_cmd_ready = cmd_ready;
		next_resp_valid = 1'b0;
		next_wr_ready = 1'b0;
		next_push_valid = push_valid;
		go_byte = 1'b0;
		go_val = 8'h00;
		go_rd = 1'b0;
		go_nack = 1'b0;
		go_seg = 1'b0;
		go_state = ST_STOP;
		bval = rd_dir ? rxb : byte_val;
		crc_new = smm_crc8(crc, bval);
		rcount = (rxb > 8'(MAX_BLOCK)) ? MAX_BLOCK : rxb[5:0];
		// Clock released in quarter 2: a slave holding it low stretches the bit
		stretched = (st == ST_START || st == ST_BYTE || st == ST_STOP) && q == 2'h2 && !scl_s;
		qend = (tick == 8'h00) && !stretched;
		if (stretched && tick == 8'h00) begin
			next_wdog = wdog + 1'b1;
		end else begin
			next_wdog = '0;
		end
		unique case (st)
			ST_IDLE: begin
				if (cmd_valid && cmd_ready) begin
					next_cur = cmd;
					next_cmd_ready = 1'b0;
					next_resp = '0;
					next_crc = 8'h00;
					next_step = (cmd.op == OP_RECV || cmd.op == OP_ARA) ? SP_RADDR : SP_ADDR;
					go_seg = 1'b1;
					go_state = ST_START;
				end else begin
					// Ready one edge after reset; stop and timeout raise it on the same edge that returns to idle
					next_cmd_ready = 1'b1;
				end
			end
			ST_START: begin
				// Start and repeated start share one shape: SDA falls while SCL is high
				if (qend) begin
					next_tick = QUARTER_TOP;
					next_q = q + 2'h1;
					unique case (q)
						2'h0: next_sda_oe = 1'b0;
						2'h1: next_scl_oe = 1'b0;
						2'h2: next_sda_oe = 1'b1;
						2'h3: begin
							go_byte = 1'b1;
							go_val = {(cur.op == OP_ARA) ? ALERT_RESP_ADDR : cur.addr, step == SP_RADDR};
						end
					endcase
				end
			end
			ST_STOP: begin
				if (qend) begin
					next_tick = QUARTER_TOP;
					next_q = q + 2'h1;
					unique case (q)
						2'h0: next_sda_oe = 1'b1;
						2'h1: next_scl_oe = 1'b0;
						2'h2: next_sda_oe = 1'b0;
						2'h3: begin
							next_st = ST_IDLE;
							next_resp_valid = 1'b1;
							next_cmd_ready = 1'b1;
						end
					endcase
				end
			end
			ST_BYTE: begin
				if (qend) begin
					next_tick = QUARTER_TOP;
					next_q = q + 2'h1;
					unique case (q)
						2'h0: begin
							// Data changes a quarter after SCL falls, well clear of the edge
							if (bitn == 4'h8) begin
								next_sda_oe = rd_dir ? !nack_out : 1'b0;
							end else begin
								next_sda_oe = rd_dir ? 1'b0 : !txb[7];
							end
						end
						2'h1: next_scl_oe = 1'b0;
						2'h2: begin
						end
						2'h3: begin
							if (bitn != 4'h8) begin
								next_txb = {txb[6:0], 1'b0};
								next_rxb = {rxb[6:0], sda_s};
								next_bitn = bitn + 4'h1;
								next_scl_oe = 1'b1;
							end else begin
								next_crc = crc_new;
								if (!rd_dir && sda_s) begin
									// Refused byte ends the transfer
									if (step == SP_WPEC) begin
										next_resp.pec_bad = 1'b1;
									end else begin
										next_resp.nack = 1'b1;
									end
									go_seg = 1'b1;
								end else begin
									unique case (step)
										SP_ADDR: begin
											next_step = SP_CMD;
											go_byte = 1'b1;
											go_val = (cur.op == OP_BLK_WR) ? BLOCK_WR_CODE :
												(cur.op == OP_BLK_RD) ? BLOCK_RD_CODE : cur.code;
										end
										SP_CMD: begin
											unique case (cur.op)
												OP_WRITE: begin
													next_step = SP_DATA;
													go_byte = 1'b1;
													go_val = cur.data;
												end
												OP_BLK_WR: begin
													next_step = SP_WBLK;
													next_cnt = cur.count;
													next_st = ST_FETCH;
												end
												OP_SEND_RECV, OP_BLK_RD: begin
													next_step = SP_RADDR;
													go_seg = 1'b1;
													go_state = ST_START;
												end
												OP_SEND, OP_RECV, OP_ARA: go_seg = 1'b1;
											endcase
										end
										SP_WBLK: begin
											next_cnt = cnt - 6'h01;
											if (cnt == 6'h01) begin
												if (cur.pec_en) begin
													next_step = SP_WPEC;
													go_byte = 1'b1;
													go_val = crc_new;
												end else begin
													go_seg = 1'b1;
												end
											end else begin
												next_st = ST_FETCH;
											end
										end
										SP_RADDR: begin
											go_byte = 1'b1;
											go_rd = 1'b1;
											if (cur.op == OP_BLK_RD) begin
												next_step = SP_RCOUNT;
											end else begin
												next_step = SP_RBYTE;
												go_nack = 1'b1;
											end
										end
										SP_RCOUNT: begin
											next_cnt = rcount;
											if (rcount == 6'h00) begin
												go_seg = 1'b1;
											end else begin
												next_step = SP_RDATA;
												go_byte = 1'b1;
												go_rd = 1'b1;
												go_nack = (rcount == 6'h01) && !cur.pec_en;
											end
										end
										SP_RDATA: begin
											next_push_valid = 1'b1;
											next_st = ST_PUSH;
										end
										SP_RBYTE: begin
											next_resp.data = rxb;
											go_seg = 1'b1;
										end
										SP_RPEC: begin
											next_resp.pec_bad = (crc_new != 8'h00);
											go_seg = 1'b1;
										end
										SP_DATA, SP_WPEC: go_seg = 1'b1;
									endcase
								end
							end
						end
					endcase
				end
			end
			ST_FETCH: begin
				// SCL stays high between bytes while the user supplies data
				if (wr_valid && !wr_ready) begin
					next_wr_ready = 1'b1;
					go_byte = 1'b1;
					go_val = wr_data;
				end
			end
			ST_PUSH: begin
				if (fifo_in_ready) begin
					next_push_valid = 1'b0;
					next_cnt = cnt - 6'h01;
					go_byte = 1'b1;
					go_rd = 1'b1;
					if (cnt == 6'h01) begin
						if (cur.pec_en) begin
							next_step = SP_RPEC;
							go_nack = 1'b1;
						end else begin
							go_byte = 1'b0;
							go_seg = 1'b1;
						end
					end else begin
						go_nack = (cnt == 6'h02) && !cur.pec_en;
					end
				end
			end
		endcase
		if (go_byte) begin
			next_st = ST_BYTE;
			next_txb = go_val;
			next_byte_val = go_val;
			next_rd_dir = go_rd;
			next_nack_out = go_nack;
			next_bitn = 4'h0;
			next_q = 2'h0;
			next_tick = QUARTER_TOP;
			next_scl_oe = 1'b1;
		end
		if (go_seg) begin
			next_st = go_state;
			next_q = 2'h0;
			next_tick = QUARTER_TOP;
			next_scl_oe = 1'b1;
		end
		// A clock held low past the bus timeout means the slave gave up: drop everything
		if (stretched && wdog == WDOG_W'(TIMEOUT - 1)) begin
			next_st = ST_IDLE;
			next_scl_oe = 1'b0;
			next_sda_oe = 1'b0;
			next_push_valid = 1'b0;
			next_resp.timeout = 1'b1;
			next_resp_valid = 1'b1;
			next_cmd_ready = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st <= ST_IDLE;
			step <= SP_ADDR;
			cur <= '0;
			resp <= '0;
			q <= 2'h0;
			tick <= 8'h00;
			bitn <= 4'h0;
			txb <= 8'h00;
			rxb <= 8'h00;
			byte_val <= 8'h00;
			crc <= 8'h00;
			rd_dir <= 1'b0;
			nack_out <= 1'b0;
			cnt <= 6'h00;
			wdog <= '0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			cmd_ready <= 1'b0;
			resp_valid <= 1'b0;
			wr_ready <= 1'b0;
			push_valid <= 1'b0;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			alert_seen <= 1'b0;
		end else if (ce) begin
			st <= next_st;
			step <= next_step;
			cur <= next_cur;
			resp <= next_resp;
			q <= next_q;
			tick <= next_tick;
			bitn <= next_bitn;
			txb <= next_txb;
			rxb <= next_rxb;
			byte_val <= next_byte_val;
			crc <= next_crc;
			rd_dir <= next_rd_dir;
			nack_out <= next_nack_out;
			cnt <= next_cnt;
			wdog <= next_wdog;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			cmd_ready <= next_cmd_ready;
			resp_valid <= next_resp_valid;
			wr_ready <= next_wr_ready;
			push_valid <= next_push_valid;
			scl_out <= 1'b0;
			sda_out <= 1'b0;
			alert_seen <= !sync2[2];
		end
	end
endmodule
`default_nettype wire

/* smm_host_chk.sv */
// Port assertions for the system-bus master
`timescale 1ns/1ps
`default_nettype none
module smm_host_chk #(
	parameter int TIMEOUT = 200
) (
	// Clock and control
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	// Command side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic resp_valid,
	// Data sides
	input wire logic wr_ready,
	input wire logic rd_valid,
	input wire logic rd_ready,
	input wire logic [7:0] rd_data,
	// Bus pins
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic alert_n_in,
	input wire logic alert_seen
);
	import smm_pkg::*;
	logic [15:0] stall;
	logic [15:0] next_stall;

	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// Cycles a busy transfer sees the clock wire held low by the far side
	always_comb begin
		next_stall = (!cmd_ready && !scl_oe && !scl_in) ? stall + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clock) begin
		stall <= srst ? 16'h0000 : next_stall;
	end

	// Steps of a transfer
	sequence s_take;
		cmd_valid && cmd_ready && ce;
	endsequence
	sequence s_start;
		!scl_oe && sda_oe;
	endsequence

	property p_open_drain;
		!scl_out && !sda_out;
	endproperty
	property p_reset;
		$fell(srst) |-> !cmd_ready && !scl_oe && !sda_oe && !resp_valid;
	endproperty
	property p_take;
		s_take |=> !cmd_ready;
	endproperty
	property p_start;
		s_take |-> ##[1:220] s_start;
	endproperty
	property p_end;
		resp_valid |-> cmd_ready && !scl_oe && !sda_oe ##1 !resp_valid;
	endproperty
	property p_timeout;
		stall <= 16'(TIMEOUT + QUARTER_CYC + 8);
	endproperty
	property p_alert_on;
		!alert_n_in [*4] |-> alert_seen;
	endproperty
	property p_alert_off;
		alert_n_in [*4] |-> !alert_seen;
	endproperty
	property p_wr_pulse;
		wr_ready |=> !wr_ready;
	endproperty
	property p_rd_hold;
		rd_valid && !rd_ready |=> rd_valid && $stable(rd_data);
	endproperty

	a_open_drain: assert property (p_open_drain) else $error("bus output driven high");
	a_reset: assert property (p_reset) else $error("outputs not idle after reset");
	a_take: assert property (p_take) else $error("ready stayed high after take");
	a_start: assert property (p_start) else $error("no start condition");
	a_end: assert property (p_end) else $error("lines not released at response");
	a_timeout: assert property (p_timeout) else $error("held clock not abandoned");
	a_alert_on: assert property (p_alert_on) else $error("alert low not seen");
	a_alert_off: assert property (p_alert_off) else $error("alert seen while high");
	a_wr_pulse: assert property (p_wr_pulse) else $error("write ready longer than a cycle");
	a_rd_hold: assert property (p_rd_hold) else $error("read byte dropped or changed");
endmodule
bind smm_host smm_host_chk #(.TIMEOUT(TIMEOUT)) u_chk (.clock, .srst, .ce, .cmd_valid, .cmd_ready,
	.resp_valid, .wr_ready, .rd_valid, .rd_ready, .rd_data, .scl_in, .scl_out, .scl_oe, .sda_out,
	.sda_oe, .alert_n_in, .alert_seen);
`default_nettype wire

/* smm_host_tb_top.sv */
// Self-checking bench for the system-bus master
`timescale 1ns/1ps
`default_nettype none
module smm_host_tb_top;
	import smm_pkg::*;
	localparam logic [6:0] A = DEV_ADDR_FLOAT;
	logic clock = 1'b0, srst = 1'b1, ce = 1'b1, cmd_valid = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
	logic alert_req = 1'b0, slow = 1'b0, hang = 1'b0, bad_pec = 1'b0, hold_rd = 1'b1;
	logic [7:0] wr_data = 8'h00;
	smm_cmd_t cmd = '0;
	smm_resp_t resp;
	logic cmd_ready, resp_valid, wr_ready, rd_valid, scl_oe, sda_oe, sl_a, sl_b, dl_a, dl_b, an_a, an_b;
	logic [7:0] rd_data;
	logic [11:0] e;
	logic [11:0] eq [$];
	logic [7:0] rq [$], wq [$];
	int error_cnt = 0, tests_run = 0;
	// Wired-and bus with pull-ups
	wire scl = !(scl_oe || sl_a || sl_b);
	wire sda = !(sda_oe || dl_a || dl_b);
	wire alert_n = an_a && an_b;

	always #25 clock = !clock;

	smm_host #(.TIMEOUT(200)) dut (.clock, .srst, .ce, .cmd_valid, .cmd_ready, .cmd, .resp_valid, .resp,
		.wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_ready, .rd_data, .scl_in(scl), .scl_out(),
		.scl_oe, .sda_in(sda), .sda_out(), .sda_oe, .alert_n_in(alert_n), .alert_seen());
	smm_dev_model #(.ADDR(DEV_ADDR_FLOAT)) dev_a (.scl, .sda, .scl_low(sl_a), .sda_low(dl_a),
		.alert_n(an_a), .alert_req, .slow, .hang, .bad_pec);
	smm_dev_model #(.ADDR(DEV_ADDR_LOW)) dev_b (.scl, .sda, .scl_low(sl_b), .sda_low(dl_b),
		.alert_n(an_b), .alert_req, .slow(1'b0), .hang(1'b0), .bad_pec(1'b0));

	task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
		tests_run++;
		if (exp !== got) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Offer one command, note its answer {check data, data, nack, pec_bad, timeout}, wait for it
	task automatic run(input smm_op_t op, input logic [6:0] ad, input logic [7:0] code, input logic [7:0] d,
		input logic [5:0] cnt, input logic [11:0] exp);
		eq.push_back(exp);
		while (cmd_ready !== 1'b1) @(negedge clock);
		cmd_valid = 1'b1;
		cmd = {op, ad, code, d, cnt, 1'b1};
		@(negedge clock);
		cmd_valid = 1'b0;
		while (eq.size() != 0) @(negedge clock);
	endtask

	// Responses and read bytes against the oldest notes
	always @(posedge clock) begin
		if (resp_valid === 1'b1) begin
			e = eq.pop_front();
			check("resp", {e[11] ? e[10:3] : resp.data, e[2:0]}, resp);
		end
		if (rd_valid === 1'b1 && rd_ready === 1'b1) check("rd_data", {rq.pop_front(), 3'b000}, {rd_data, 3'b000});
	end

	// Write source advances on the taken pulse; the reader stalls at random
	always @(negedge clock) begin
		if (wr_ready === 1'b1) void'(wq.pop_front());
		wr_valid <= wq.size() != 0;
		wr_data <= wq.size() != 0 ? wq[0] : 8'($urandom);
		rd_ready <= hold_rd ? 1'b0 : 1'($urandom);
	end

	// Span of 5 ms, only a little beyond the whole sequence
	initial begin
		#(100000 * 50);
		error_cnt++;
		finish_test();
	end

	initial begin
		logic [7:0] d1, d2;
		void'($urandom(77229));
		repeat (12) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		// Eight-byte read into a stalled buffer, then drained; short enough to keep the run brief
		run(OP_WRITE, A, 8'h00, 8'h08, 6'h00, 12'h000);
		run(OP_SEND, A, 8'h40, 8'h00, 6'h00, 12'h000);
		for (int i = 0; i < 8; i++) rq.push_back((8'h40 + 8'(i)) ^ 8'h5a);
		run(OP_BLK_RD, A, 8'h00, 8'h00, 6'h08, 12'h000);
		hold_rd = 1'b0;
		while (rq.size() != 0) @(negedge clock);
		// One-byte block write, read back through a repeated start
		run(OP_WRITE, A, 8'h00, 8'h01, 6'h00, 12'h000);
		run(OP_SEND, A, 8'h10, 8'h00, 6'h00, 12'h000);
		d1 = 8'($urandom);
		wq.push_back(d1);
		run(OP_BLK_WR, A, 8'h00, 8'h00, 6'h01, 12'h000);
		run(OP_SEND_RECV, A, 8'h10, 8'h00, 6'h00, {1'b1, d1, 3'b000});
		// Check byte refused on write, corrupted on read
		bad_pec = 1'b1;
		d2 = 8'($urandom);
		wq.push_back(d2);
		run(OP_BLK_WR, A, 8'h00, 8'h00, 6'h01, 12'h002);
		rq.push_back(d2);
		run(OP_BLK_RD, A, 8'h00, 8'h00, 6'h01, 12'h002);
		bad_pec = 1'b0;
		slow = 1'b1;
		run(OP_RECV, A, 8'h00, 8'h00, 6'h00, {1'b1, d2, 3'b000});
		slow = 1'b0;
		run(OP_SEND, 7'h33, 8'h10, 8'h00, 6'h00, 12'h004);
		// Both devices alert; the lower address wins
		alert_req = 1'b1;
		run(OP_ARA, ALERT_RESP_ADDR, 8'h00, 8'h00, 6'h00, {1'b1, DEV_ADDR_LOW, 1'b1, 3'b000});
		alert_req = 1'b0;
		// Clock held low by the device, then a clean transfer afterwards
		hang = 1'b1;
		run(OP_SEND, A, 8'h10, 8'h00, 6'h00, 12'h001);
		hang = 1'b0;
		run(OP_SEND, A, 8'h10, 8'h00, 6'h00, 12'h000);
		finish_test();
	end
endmodule
`default_nettype wire

/* smm_pkg.sv */
// Shared constants, types and the CRC helper for the system-bus master
package smm_pkg;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int SCL_HZ = 100_000;
	localparam int QUARTER_CYC = CLK_HZ / (4 * SCL_HZ);
	localparam logic [7:0] QUARTER_TOP = 8'(QUARTER_CYC - 1);
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
	localparam int WDOG_W = 20;
	// Protocol codes
	localparam logic [7:0] BLOCK_WR_CODE = 8'ha0;
	localparam logic [7:0] BLOCK_RD_CODE = 8'ha1;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
	localparam logic [6:0] DEV_ADDR_FLOAT = 7'h5c;
	localparam logic [6:0] DEV_ADDR_LOW = 7'h58;
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h61;
	localparam logic [7:0] CFG3_REG = 8'h03;
	localparam int CFG3_SCL_TIMEOUT_BIT = 1;
	localparam int CFG3_SDA_TIMEOUT_BIT = 2;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [5:0] MAX_BLOCK = 6'h20;
	// Buffering
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {OP_SEND, OP_WRITE, OP_RECV, OP_SEND_RECV, OP_BLK_WR, OP_BLK_RD, OP_ARA} smm_op_t;

	typedef struct packed {
		smm_op_t op;
		logic [6:0] addr;
		logic [7:0] code;
		logic [7:0] data;
		logic [5:0] count;
		logic pec_en;
	} smm_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic nack;
		logic pec_bad;
		logic timeout;
	} smm_resp_t;

	// One byte through the CRC-8 shift register
	function automatic logic [7:0] smm_crc8(input logic [7:0] crc, input logic [7:0] b);
		logic [7:0] c;
		c = crc ^ b;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction
endpackage
